/* logic/apr_pkg.sv */
/*
 * apr_pkg: register map, field positions, reset values, channel numbers
 * and timing constants for the front-end protection and routing block.
 * Assumes a 200 MHz hclk and a single AHB-Lite master.
 */
package apr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_TRIP_MASK = 8'h08;
  localparam logic [7:0] OFS_CMP_STAT = 8'h0C;
  localparam logic [7:0] OFS_DAC = 8'h10;
  localparam logic [7:0] OFS_MUX = 8'h14;
  localparam logic [7:0] OFS_AIO_CFG = 8'h18;
  localparam logic [7:0] OFS_AIO_DATA = 8'h1C;
  localparam logic [7:0] OFS_AIO_ROUTE = 8'h20;
  localparam logic [7:0] OFS_EDGE_MASK = 8'h24;
  localparam logic [7:0] OFS_EVENT = 8'h28;
  localparam logic [7:0] OFS_STATE = 8'h2C;
  localparam logic [7:0] OFS_GP_ROUTE = 8'h30;

  // control register bits
  localparam int CTRL_PUSH_BUTTON_INPUT_EN = 0;
  localparam int CTRL_PUSH_BUTTON_INPUT_LOW = 1;
  localparam int CTRL_HIB_REQ = 2;
  localparam int CTRL_ADC_AUTO = 3;
  localparam int CTRL_AFE_AUTO = 4;
  localparam int CTRL_FT_DAC_BUS = 5;
  localparam int CTRL_CL_DAC_BUS = 6;
  localparam int CTRL_TEMP_IRQ = 7;

  // field positions inside shared words
  localparam int DAC_CL_LSB = 16;
  localparam int MUX_AFE_LSB = 4;
  localparam int MUX_SMON_LSB = 8;
  localparam int AIO_POL_LSB = 16;
  localparam int EDGE_FALL_LSB = 4;
  localparam int EVT_PUSH_BUTTON_INPUT = 8;
  localparam int ST_WARN = 0;
  localparam int ST_SHDN = 1;
  localparam int ST_HIB = 2;
  localparam int ST_IRQ_MAIN = 3;
  localparam int ST_IRQ_SEC = 4;

  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [9:0] RST_DAC = 10'h3FF;
  localparam logic [9:0] RST_AIO_POL = 10'h000;

  // channel and line numbers, dac full scale in mV
  localparam logic [2:0] ADC_CH_AFE = 3'h0;
  localparam logic [2:0] ADC_CH_PIN_LO = 3'h4;
  localparam logic [3:0] AFE_CH_SUPPLY = 4'hB;
  localparam int AIO_EDGE_LO = 6;
  localparam int DAC_FS_MV = 2500;

  // timing
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int HOLD_TIME_MS = 4000;
  localparam int HOLD_CYCLES = HOLD_TIME_MS * CLK_FREQ_KHZ;
  localparam int BLANK_TIME_US = 100;
  localparam int BLANK_CYCLES = BLANK_TIME_US * CLK_FREQ_KHZ / 1000;

  // power-button state, gray coded along run -> hibernate -> reset
  typedef enum logic [1:0] {
    APR_RUN = 2'b00,
    APR_HIB = 2'b01,
    APR_RST = 2'b11
  } apr_pwr_t;

endpackage

/* logic/apr_top.sv */
/*
 * apr_top: digital side of the motor front end - protection comparator
 * masks, fault trip, analog I/O pins, push button, mux selects, routing
 * and thermal response, with an AHB-Lite register slave.
 * Assumes analog inputs already sampled at hclk level, one bus master,
 * and no byte writes (whole words only).
 */
module apr_top #(
  parameter int N_PROTECTION_COMPARATOR = 6,
  parameter int N_AIO = 10,
  parameter int N_DBL = 7,
  parameter int N_GPC = 4,
  parameter int HOLD_CYCLES = apr_pkg::HOLD_CYCLES,
  parameter int BLANK_CYCLES = apr_pkg::BLANK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // protection comparators
  input wire logic [N_PROTECTION_COMPARATOR-1:0] protection_comparator_i,
  output logic fault_trip_event,
  output logic [9:0] fast_trip_dac_code,
  output logic [9:0] current_limit_dac_code,
  // analog i/o pins, open drain
  input wire logic [N_AIO-1:0] analog_io_pin_i,
  output logic [N_AIO-1:0] analog_io_pin_o,
  output logic [N_AIO-1:0] analog_io_pin_oe_n,
  // digital route matrix lines
  input wire logic [N_DBL-1:0] digital_bus_line_i,
  output logic [N_DBL-1:0] digital_bus_line_o,
  output logic [N_DBL-1:0] digital_bus_line_oe_n,
  // general-purpose comparator outputs
  input wire logic [N_GPC-1:0] gp_comparator_i,
  // push button
  input wire logic push_button_input,
  output logic mcu_reset,
  output logic hibernate,
  // multiplexer selects
  input wire logic [2:0] seq_adc_sel,
  input wire logic [3:0] fast_channel_select,
  output logic [2:0] adc_mux_sel,
  output logic [3:0] afe_mux_sel,
  output logic [2:0] supply_monitor_mux_sel,
  output logic adc_takes_afe,
  output logic adc_takes_pin,
  output logic afe_takes_supply,
  // analog route matrix
  output logic fast_trip_dac_to_bus,
  output logic current_limit_dac_to_bus,
  // temperature sensing and response
  input wire logic temp_warn_above,
  input wire logic temp_warn_hyst_above,
  input wire logic temp_fault_above,
  input wire logic temp_fault_hyst_above,
  output logic power_shutdown,
  // interrupts to the microcontroller
  output logic main_interrupt_line,
  output logic secondary_interrupt_line
);

  localparam int NE = N_AIO - apr_pkg::AIO_EDGE_LO;

  typedef struct packed {
    logic hready;
    logic [31:0] rdata;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] ctrl;
    logic [N_PROTECTION_COMPARATOR-1:0] irq_mask;
    logic [N_PROTECTION_COMPARATOR-1:0] trip_mask;
    logic [9:0] ft_dac;
    logic [9:0] cl_dac;
    logic [2:0] adc_sel;
    logic [3:0] afe_sel;
    logic [2:0] smon_sel;
    logic [N_AIO-1:0] aio_dir;
    logic [N_AIO-1:0] aio_pol;
    logic [N_AIO-1:0] aio_dout;
    logic [3*N_AIO-1:0] aio_route;
    logic [3*N_GPC-1:0] gp_route;
    logic [NE-1:0] rise_mask;
    logic [NE-1:0] fall_mask;
    logic [2*NE-1:0] edge_pend;
    logic push_button_input_evt;
    logic [N_PROTECTION_COMPARATOR-1:0] cmp_s1;
    logic [N_PROTECTION_COMPARATOR-1:0] cmp_s2;
    logic [N_AIO-1:0] aio_s1;
    logic [N_AIO-1:0] aio_s2;
    logic [NE-1:0] edge_prev;
    logic pb_s1;
    logic pb_s2;
    logic press_prev;
    logic [3:0] tmp_s1;
    logic [3:0] tmp_s2;
    apr_pkg::apr_pwr_t pwr;
    logic [31:0] hold_cnt;
    logic warn;
    logic [31:0] warn_cnt;
    logic shdn;
    logic [31:0] shdn_cnt;
    logic irq_main;
    logic irq_sec;
    logic [N_AIO-1:0] aio_oe_n;
    logic [N_DBL-1:0] dbl_o;
    logic [N_DBL-1:0] dbl_oe_n;
    logic [2:0] adc_o;
    logic [3:0] afe_o;
    logic adc_afe;
    logic adc_pin;
    logic afe_sup;
  } apr_state_t;

  apr_state_t st_ff;
  apr_state_t nxt_st;

  function automatic logic route_hit(input logic [2:0] sel, input int line);
    route_hit = (sel == 3'(line + 1));
  endfunction

  // fault trip must not wait for a clock edge: the driver stage acts on it
  assign fault_trip_event = |(protection_comparator_i & st_ff.trip_mask);

  // open drain: the pin is only ever pulled low
  assign analog_io_pin_o = '0;

  always_comb begin
    logic [N_AIO-1:0] aio_log;
    logic [2:0] r;
    logic v;
    logic drv;
    logic val;
    logic press;
    logic [3:0] tmp;
    logic [31:0] rd;
    logic [31:0] wd;
    aio_log = '0;
    r = '0;
    v = 1'b0;
    drv = 1'b0;
    val = 1'b0;
    press = 1'b0;
    tmp = '0;
    rd = '0;
    wd = hwdata;
    nxt_st = st_ff;

    // synchronizers
    nxt_st.cmp_s1 = protection_comparator_i;
    nxt_st.cmp_s2 = st_ff.cmp_s1;
    nxt_st.aio_s1 = analog_io_pin_i;
    nxt_st.aio_s2 = st_ff.aio_s1;
    nxt_st.pb_s1 = push_button_input;
    nxt_st.pb_s2 = st_ff.pb_s1;
    nxt_st.tmp_s1 = {temp_fault_hyst_above, temp_fault_above,
                     temp_warn_hyst_above, temp_warn_above};
    nxt_st.tmp_s2 = st_ff.tmp_s1;
    tmp = st_ff.tmp_s2;

    // pin inputs seen through polarity
    aio_log = st_ff.aio_s2 ^ st_ff.aio_pol;

    // pin drive: register bit or a bus line, then polarity, open drain
    for (int i = 0; i < N_AIO; i++) begin
      r = st_ff.aio_route[3*i +: 3];
      if (r == 3'h0) begin
        v = st_ff.aio_dout[i];
      end else begin
        v = digital_bus_line_i[r - 3'h1];
      end
      nxt_st.aio_oe_n[i] = ~(st_ff.aio_dir[i] & ~(v ^ st_ff.aio_pol[i]));
    end

    // digital bus lines carry input pins and gp comparators
    for (int j = 0; j < N_DBL; j++) begin
      drv = 1'b0;
      val = 1'b0;
      for (int i = 0; i < N_AIO; i++) begin
        if (!st_ff.aio_dir[i] && route_hit(st_ff.aio_route[3*i +: 3], j)) begin
          drv = 1'b1;
          val = val | aio_log[i];
        end
      end
      for (int k = 0; k < N_GPC; k++) begin
        if (route_hit(st_ff.gp_route[3*k +: 3], j)) begin
          drv = 1'b1;
          val = val | gp_comparator_i[k];
        end
      end
      nxt_st.dbl_o[j] = val;
      nxt_st.dbl_oe_n[j] = ~drv;
    end

    // edge events on the upper pins, set wins over software clear
    for (int k = 0; k < NE; k++) begin
      nxt_st.edge_prev[k] = aio_log[apr_pkg::AIO_EDGE_LO + k];
    end
    if (st_ff.wr_pend && st_ff.wr_addr == apr_pkg::OFS_EVENT) begin
      nxt_st.edge_pend = st_ff.edge_pend & ~wd[2*NE-1:0];
      nxt_st.push_button_input_evt = st_ff.push_button_input_evt & ~wd[apr_pkg::EVT_PUSH_BUTTON_INPUT];
    end
    for (int k = 0; k < NE; k++) begin
      if (st_ff.rise_mask[k] && !st_ff.edge_prev[k] &&
          aio_log[apr_pkg::AIO_EDGE_LO + k]) begin
        nxt_st.edge_pend[k] = 1'b1;
      end
      if (st_ff.fall_mask[k] && st_ff.edge_prev[k] &&
          !aio_log[apr_pkg::AIO_EDGE_LO + k]) begin
        nxt_st.edge_pend[NE + k] = 1'b1;
      end
    end

    // push button
    press = st_ff.pb_s2 ^ st_ff.ctrl[apr_pkg::CTRL_PUSH_BUTTON_INPUT_LOW];
    nxt_st.press_prev = press;
    if (press && !st_ff.press_prev && st_ff.ctrl[apr_pkg::CTRL_PUSH_BUTTON_INPUT_EN]) begin
      nxt_st.push_button_input_evt = 1'b1;
    end
    case (st_ff.pwr)
      apr_pkg::APR_RUN: begin
        if (press) begin
          if (st_ff.hold_cnt == 32'(HOLD_CYCLES)) begin
            nxt_st.pwr = apr_pkg::APR_RST;
          end else begin
            nxt_st.hold_cnt = st_ff.hold_cnt + 32'h1;
          end
        end else begin
          nxt_st.hold_cnt = '0;
        end
        if (st_ff.wr_pend && st_ff.wr_addr == apr_pkg::OFS_CTRL &&
            wd[apr_pkg::CTRL_HIB_REQ] && wd[apr_pkg::CTRL_PUSH_BUTTON_INPUT_EN]) begin
          nxt_st.pwr = apr_pkg::APR_HIB;
          nxt_st.hold_cnt = '0;
        end
      end
      apr_pkg::APR_HIB: begin
        if (press && !st_ff.press_prev) begin
          nxt_st.pwr = apr_pkg::APR_RUN;
        end
      end
      apr_pkg::APR_RST: begin
        // reset stands until the button is let go
        if (!press) begin
          nxt_st.pwr = apr_pkg::APR_RUN;
          nxt_st.hold_cnt = '0;
        end
      end
      default: begin
        nxt_st.pwr = apr_pkg::APR_RUN;
      end
    endcase

    // thermal warning
    if (tmp[0]) begin
      nxt_st.warn = 1'b1;
      nxt_st.warn_cnt = '0;
    end else if (st_ff.warn && !tmp[1]) begin
      if (st_ff.warn_cnt == 32'(BLANK_CYCLES)) begin
        nxt_st.warn = 1'b0;
        nxt_st.warn_cnt = '0;
      end else begin
        nxt_st.warn_cnt = st_ff.warn_cnt + 32'h1;
      end
    end else begin
      nxt_st.warn_cnt = '0;
    end

    // thermal shutdown
    if (tmp[2]) begin
      nxt_st.shdn = 1'b1;
      nxt_st.shdn_cnt = '0;
    end else if (st_ff.shdn && !tmp[3]) begin
      if (st_ff.shdn_cnt == 32'(BLANK_CYCLES)) begin
        nxt_st.shdn = 1'b0;
        nxt_st.shdn_cnt = '0;
      end else begin
        nxt_st.shdn_cnt = st_ff.shdn_cnt + 32'h1;
      end
    end else begin
      nxt_st.shdn_cnt = '0;
    end

    // interrupts
    nxt_st.irq_main = |(st_ff.cmp_s2 & st_ff.irq_mask) |
                      (st_ff.warn & st_ff.ctrl[apr_pkg::CTRL_TEMP_IRQ]);
    nxt_st.irq_sec = |st_ff.edge_pend;

    // mux selects
    if (st_ff.ctrl[apr_pkg::CTRL_ADC_AUTO]) begin
      nxt_st.adc_o = seq_adc_sel;
    end else begin
      nxt_st.adc_o = st_ff.adc_sel;
    end
    if (st_ff.ctrl[apr_pkg::CTRL_AFE_AUTO]) begin
      nxt_st.afe_o = fast_channel_select;
    end else begin
      nxt_st.afe_o = st_ff.afe_sel;
    end
    nxt_st.adc_afe = (nxt_st.adc_o == apr_pkg::ADC_CH_AFE);
    nxt_st.adc_pin = (nxt_st.adc_o >= apr_pkg::ADC_CH_PIN_LO);
    nxt_st.afe_sup = (nxt_st.afe_o == apr_pkg::AFE_CH_SUPPLY);

    // bus data phase: register writes
    if (st_ff.wr_pend) begin
      if (st_ff.wr_addr == apr_pkg::OFS_CTRL) begin
        nxt_st.ctrl = wd[7:0] & ~(8'h01 << apr_pkg::CTRL_HIB_REQ);
      end else if (st_ff.wr_addr == apr_pkg::OFS_IRQ_MASK) begin
        nxt_st.irq_mask = wd[N_PROTECTION_COMPARATOR-1:0];
      end else if (st_ff.wr_addr == apr_pkg::OFS_TRIP_MASK) begin
        nxt_st.trip_mask = wd[N_PROTECTION_COMPARATOR-1:0];
      end else if (st_ff.wr_addr == apr_pkg::OFS_DAC) begin
        nxt_st.ft_dac = wd[9:0];
        nxt_st.cl_dac = wd[apr_pkg::DAC_CL_LSB +: 10];
      end else if (st_ff.wr_addr == apr_pkg::OFS_MUX) begin
        nxt_st.adc_sel = wd[2:0];
        nxt_st.afe_sel = wd[apr_pkg::MUX_AFE_LSB +: 4];
        nxt_st.smon_sel = wd[apr_pkg::MUX_SMON_LSB +: 3];
      end else if (st_ff.wr_addr == apr_pkg::OFS_AIO_CFG) begin
        nxt_st.aio_dir = wd[N_AIO-1:0];
        nxt_st.aio_pol = wd[apr_pkg::AIO_POL_LSB +: N_AIO];
      end else if (st_ff.wr_addr == apr_pkg::OFS_AIO_DATA) begin
        nxt_st.aio_dout = wd[N_AIO-1:0];
      end else if (st_ff.wr_addr == apr_pkg::OFS_AIO_ROUTE) begin
        nxt_st.aio_route = wd[3*N_AIO-1:0];
      end else if (st_ff.wr_addr == apr_pkg::OFS_EDGE_MASK) begin
        nxt_st.rise_mask = wd[NE-1:0];
        nxt_st.fall_mask = wd[apr_pkg::EDGE_FALL_LSB +: NE];
      end else if (st_ff.wr_addr == apr_pkg::OFS_GP_ROUTE) begin
        nxt_st.gp_route = wd[3*N_GPC-1:0];
      end
    end

    // bus address phase: reads are sampled here, writes land next cycle
    if (st_ff.wr_addr == apr_pkg::OFS_CTRL) begin
      rd = '0;
    end
    if (haddr[7:0] == apr_pkg::OFS_CTRL) begin
      rd[7:0] = st_ff.ctrl;
    end else if (haddr[7:0] == apr_pkg::OFS_IRQ_MASK) begin
      rd[N_PROTECTION_COMPARATOR-1:0] = st_ff.irq_mask;
    end else if (haddr[7:0] == apr_pkg::OFS_TRIP_MASK) begin
      rd[N_PROTECTION_COMPARATOR-1:0] = st_ff.trip_mask;
    end else if (haddr[7:0] == apr_pkg::OFS_CMP_STAT) begin
      rd[N_PROTECTION_COMPARATOR-1:0] = st_ff.cmp_s2;
    end else if (haddr[7:0] == apr_pkg::OFS_DAC) begin
      rd[9:0] = st_ff.ft_dac;
      rd[apr_pkg::DAC_CL_LSB +: 10] = st_ff.cl_dac;
    end else if (haddr[7:0] == apr_pkg::OFS_MUX) begin
      rd[2:0] = st_ff.adc_sel;
      rd[apr_pkg::MUX_AFE_LSB +: 4] = st_ff.afe_sel;
      rd[apr_pkg::MUX_SMON_LSB +: 3] = st_ff.smon_sel;
    end else if (haddr[7:0] == apr_pkg::OFS_AIO_CFG) begin
      rd[N_AIO-1:0] = st_ff.aio_dir;
      rd[apr_pkg::AIO_POL_LSB +: N_AIO] = st_ff.aio_pol;
    end else if (haddr[7:0] == apr_pkg::OFS_AIO_DATA) begin
      rd[N_AIO-1:0] = aio_log;
    end else if (haddr[7:0] == apr_pkg::OFS_AIO_ROUTE) begin
      rd[3*N_AIO-1:0] = st_ff.aio_route;
    end else if (haddr[7:0] == apr_pkg::OFS_EDGE_MASK) begin
      rd[NE-1:0] = st_ff.rise_mask;
      rd[apr_pkg::EDGE_FALL_LSB +: NE] = st_ff.fall_mask;
    end else if (haddr[7:0] == apr_pkg::OFS_EVENT) begin
      rd[2*NE-1:0] = st_ff.edge_pend;
      rd[apr_pkg::EVT_PUSH_BUTTON_INPUT] = st_ff.push_button_input_evt;
    end else if (haddr[7:0] == apr_pkg::OFS_STATE) begin
      rd[apr_pkg::ST_WARN] = st_ff.warn;
      rd[apr_pkg::ST_SHDN] = st_ff.shdn;
      rd[apr_pkg::ST_HIB] = (st_ff.pwr == apr_pkg::APR_HIB);
      rd[apr_pkg::ST_IRQ_MAIN] = st_ff.irq_main;
      rd[apr_pkg::ST_IRQ_SEC] = st_ff.irq_sec;
    end else if (haddr[7:0] == apr_pkg::OFS_GP_ROUTE) begin
      rd[3*N_GPC-1:0] = st_ff.gp_route;
    end
    if (haddr[31:8] != 24'h000000) begin
      rd = '0;
    end

    nxt_st.hready = 1'b1;
    nxt_st.wr_pend = hsel && htrans[1] && hready && hwrite;
    if (hsel && htrans[1] && hready) begin
      nxt_st.wr_addr = hwrite ? haddr[7:0] : 8'hFF;
      nxt_st.rdata = hwrite ? 32'h00000000 : rd;
    end else begin
      nxt_st.wr_addr = 8'hFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.hready <= 1'b1;
      st_ff.wr_addr <= 8'hFF;
      st_ff.ctrl <= apr_pkg::RST_CTRL;
      st_ff.ft_dac <= apr_pkg::RST_DAC;
      st_ff.cl_dac <= apr_pkg::RST_DAC;
      st_ff.aio_pol <= apr_pkg::RST_AIO_POL;
      st_ff.pwr <= apr_pkg::APR_RUN;
      st_ff.aio_oe_n <= '1;
      st_ff.dbl_oe_n <= '1;
      st_ff.adc_afe <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign hrdata = st_ff.rdata;
  assign hreadyout = st_ff.hready;
  assign hresp = 1'b0;
  assign fast_trip_dac_code = st_ff.ft_dac;
  assign current_limit_dac_code = st_ff.cl_dac;
  assign analog_io_pin_oe_n = st_ff.aio_oe_n;
  assign digital_bus_line_o = st_ff.dbl_o;
  assign digital_bus_line_oe_n = st_ff.dbl_oe_n;
  assign mcu_reset = (st_ff.pwr == apr_pkg::APR_RST);
  assign hibernate = (st_ff.pwr == apr_pkg::APR_HIB);
  assign adc_mux_sel = st_ff.adc_o;
  assign afe_mux_sel = st_ff.afe_o;
  assign supply_monitor_mux_sel = st_ff.smon_sel;
  assign adc_takes_afe = st_ff.adc_afe;
  assign adc_takes_pin = st_ff.adc_pin;
  assign afe_takes_supply = st_ff.afe_sup;
  assign fast_trip_dac_to_bus = st_ff.ctrl[apr_pkg::CTRL_FT_DAC_BUS];
  assign current_limit_dac_to_bus = st_ff.ctrl[apr_pkg::CTRL_CL_DAC_BUS];
  assign power_shutdown = st_ff.shdn;
  assign main_interrupt_line = st_ff.irq_main;
  assign secondary_interrupt_line = st_ff.irq_sec;

endmodule

/* sim/apr_chk.sv */
/* apr_chk: concurrent checks on the ports of apr_top.
 * Assumes one hclk domain and the bind below. */
module apr_chk #(
  parameter int N_PROTECTION_COMPARATOR = 6,
  parameter int N_AIO = 10
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched ports
  input wire logic [N_PROTECTION_COMPARATOR-1:0] protection_comparator_i,
  input wire logic fault_trip_event,
  input wire logic [N_AIO-1:0] analog_io_pin_i,
  input wire logic [N_AIO-1:0] analog_io_pin_o,
  input wire logic mcu_reset,
  input wire logic hibernate,
  input wire logic [2:0] adc_mux_sel,
  input wire logic [3:0] afe_mux_sel,
  input wire logic adc_takes_afe,
  input wire logic adc_takes_pin,
  input wire logic afe_takes_supply,
  input wire logic temp_fault_above,
  input wire logic power_shutdown,
  input wire logic secondary_interrupt_line
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  trip_src_a:
    assert property (fault_trip_event |-> protection_comparator_i != 0)
    else $error("trip without a comparator");
  od_low_a:
    assert property (analog_io_pin_o == '0)
    else $error("pin driven high");
  shdn_cause_a:
    assert property ($rose(power_shutdown) |-> $past(temp_fault_above, 3))
    else $error("shutdown without fault level");
  pwr_excl_a:
    assert property (!(mcu_reset && hibernate))
    else $error("reset and hibernate together");
  adc_afe_a:
    assert property (adc_takes_afe == (adc_mux_sel == 3'h0))
    else $error("adc channel 0 flag wrong");
  adc_pin_a:
    assert property (adc_takes_pin == (adc_mux_sel >= 3'h4))
    else $error("adc pin channel flag wrong");
  afe_sup_a:
    assert property (afe_takes_supply == (afe_mux_sel == 4'hB))
    else $error("supply monitor flag wrong");
  // a raw edge needs two sync flops, detect and irq flop before it shows
  sec_sync_a:
    assert property ($stable(analog_io_pin_i[9:6]) [*5]
      |-> !$rose(secondary_interrupt_line))
    else $error("secondary irq without pin edge");
endmodule

bind apr_top apr_chk #(.N_PROTECTION_COMPARATOR(N_PROTECTION_COMPARATOR), .N_AIO(N_AIO)) apr_chk_inst (
  .hclk, .hresetn, .protection_comparator_i, .fault_trip_event,
  .analog_io_pin_i, .analog_io_pin_o, .mcu_reset, .hibernate,
  .adc_mux_sel, .afe_mux_sel, .adc_takes_afe, .adc_takes_pin,
  .afe_takes_supply, .temp_fault_above, .power_shutdown,
  .secondary_interrupt_line
);

/* sim/apr_drv_model.sv */
/* apr_drv_model: power driver stage behind the block.
 * Assumes trip and shutdown are level signals, active high. */
module apr_drv_model (
  // protection inputs
  input wire logic fault_trip_event,
  input wire logic power_shutdown,
  // gate state
  output logic gates_on
);
  timeunit 1ns;
  timeprecision 100ps;
  // gates drop the instant either cause is present, no clock involved
  assign gates_on = !fault_trip_event && !power_shutdown;
endmodule

/* sim/tb_apr_top.sv */
/* tb_apr_top: register-level tests of apr_top over AHB-Lite.
 * Assumes zero-wait slave; counts shortened by parameters. */
module tb_apr_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD = 20;
  localparam int BLANK = 8;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp;
  logic [5:0] protection_comparator_i = '0;
  logic [9:0] pin_ext = '1;
  logic [3:0] gp_comparator_i = '0, fast_channel_select = '0;
  logic [2:0] seq_adc_sel = '0;
  logic push_button_input = 1'b0, temp_warn_above = 1'b0;
  logic temp_warn_hyst_above = 1'b0, temp_fault_above = 1'b0;
  logic temp_fault_hyst_above = 1'b0;
  logic fault_trip_event, mcu_reset, hibernate, gates_on;
  logic adc_takes_afe, adc_takes_pin, afe_takes_supply, power_shutdown;
  logic fast_trip_dac_to_bus, current_limit_dac_to_bus;
  logic main_interrupt_line, secondary_interrupt_line;
  logic [9:0] fast_trip_dac_code, current_limit_dac_code;
  logic [9:0] analog_io_pin_i, analog_io_pin_o, analog_io_pin_oe_n;
  logic [6:0] digital_bus_line_i, digital_bus_line_o;
  logic [6:0] digital_bus_line_oe_n;
  logic [2:0] adc_mux_sel, supply_monitor_mux_sel;
  logic [3:0] afe_mux_sel;
  int num_errors = 0, compares = 0, cycles = 0;

  assign hready = hreadyout;
  // open drain with pull-up
  assign analog_io_pin_i = pin_ext & (analog_io_pin_oe_n | analog_io_pin_o);
  // a released line shows the inverse of digital_bus_line_o, which the block holds at 0 while released, so it reads high
  assign digital_bus_line_i = digital_bus_line_o ^ digital_bus_line_oe_n;

  always #2.5 hclk = ~hclk;

  apr_top #(.HOLD_CYCLES(HOLD), .BLANK_CYCLES(BLANK)) apr_top_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .protection_comparator_i,
    .fault_trip_event, .fast_trip_dac_code, .current_limit_dac_code,
    .analog_io_pin_i, .analog_io_pin_o, .analog_io_pin_oe_n,
    .digital_bus_line_i, .digital_bus_line_o, .digital_bus_line_oe_n,
    .gp_comparator_i, .push_button_input, .mcu_reset, .hibernate,
    .seq_adc_sel, .fast_channel_select, .adc_mux_sel, .afe_mux_sel,
    .supply_monitor_mux_sel, .adc_takes_afe, .adc_takes_pin,
    .afe_takes_supply, .fast_trip_dac_to_bus, .current_limit_dac_to_bus,
    .temp_warn_above, .temp_warn_hyst_above, .temp_fault_above,
    .temp_fault_hyst_above, .power_shutdown, .main_interrupt_line,
    .secondary_interrupt_line
  );

  apr_drv_model apr_drv_model_inst (
    .fault_trip_event, .power_shutdown, .gates_on
  );

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, '0, q);
    chk(q, e);
  endtask

  // outputs are looked at mid-cycle, well clear of the edges
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(apr_pkg::OFS_DAC, 32'h03FF03FF);
    rd(apr_pkg::OFS_AIO_CFG, 32'h0);
    rd(8'hFC, 32'h0);
    for (int i = 0; i < 6; i++) begin
      @(posedge hclk) protection_comparator_i <= 6'h1 << i;
      wr(apr_pkg::OFS_TRIP_MASK, 32'h3F ^ (32'h1 << i));
      wr(apr_pkg::OFS_IRQ_MASK, 32'h1 << i);
      cyc(3);
      chk(fault_trip_event, 1'b0);
      chk(main_interrupt_line, 1'b1);
      rd(apr_pkg::OFS_CMP_STAT, 32'h1 << i);
      wr(apr_pkg::OFS_TRIP_MASK, 32'h1 << i);
      wr(apr_pkg::OFS_IRQ_MASK, 32'h3F ^ (32'h1 << i));
      cyc(3);
      chk(fault_trip_event, 1'b1);
      chk(main_interrupt_line, 1'b0);
    end
    @(posedge hclk) protection_comparator_i <= '0;
    @(negedge hclk);
    chk(gates_on, 1'b1);
    wr(apr_pkg::OFS_DAC, 32'h02AA0155);
    cyc(1);
    chk({current_limit_dac_code, fast_trip_dac_code}, 20'hAA955);
    wr(apr_pkg::OFS_MUX, 32'h5B4);
    cyc(1);
    chk(supply_monitor_mux_sel, 3'h5);
    chk(afe_takes_supply, 1'b1);
    chk(adc_takes_pin, 1'b1);
    @(posedge hclk) fast_channel_select <= 4'h9;
    wr(apr_pkg::OFS_CTRL, 32'h78);
    cyc(1);
    chk(adc_mux_sel, 3'h0);
    chk({fast_trip_dac_to_bus, current_limit_dac_to_bus}, 2'b11);
    @(posedge hclk) fast_channel_select <= 4'h3;
    cyc(2);
    chk(afe_mux_sel, 4'h3);
    wr(apr_pkg::OFS_AIO_CFG, 32'h1);
    wr(apr_pkg::OFS_AIO_DATA, 32'h0);
    cyc(2);
    chk(analog_io_pin_oe_n[0], 1'b0);
    wr(apr_pkg::OFS_AIO_DATA, 32'h1);
    cyc(2);
    chk(analog_io_pin_oe_n[0], 1'b1);
    rd(apr_pkg::OFS_AIO_DATA, 32'h3FF);
    wr(apr_pkg::OFS_AIO_CFG, 32'h00020000);
    rd(apr_pkg::OFS_AIO_DATA, 32'h3FD);
    wr(apr_pkg::OFS_EDGE_MASK, 32'h1);
    @(posedge hclk) pin_ext[6] <= 1'b0;
    cyc(6);
    chk(secondary_interrupt_line, 1'b0);
    @(posedge hclk) pin_ext[6] <= 1'b1;
    cyc(6);
    chk(secondary_interrupt_line, 1'b1);
    rd(apr_pkg::OFS_EVENT, 32'h1);
    wr(apr_pkg::OFS_EDGE_MASK, 32'h80);
    wr(apr_pkg::OFS_EVENT, 32'h1FF);
    cyc(2);
    chk(secondary_interrupt_line, 1'b0);
    @(posedge hclk) pin_ext[9] <= 1'b0;
    cyc(6);
    chk(secondary_interrupt_line, 1'b1);
    wr(apr_pkg::OFS_EVENT, 32'h1FF);
    wr(apr_pkg::OFS_AIO_ROUTE, 32'h00600000);
    wr(apr_pkg::OFS_GP_ROUTE, 32'h5);
    @(posedge hclk) gp_comparator_i <= 4'h1;
    cyc(4);
    chk(digital_bus_line_oe_n[4:2], 3'b010);
    chk({digital_bus_line_o[4], digital_bus_line_o[2]}, 2'b11);
    wr(apr_pkg::OFS_CTRL, 32'h1);
    @(posedge hclk) push_button_input <= 1'b1;
    cyc(3);
    @(posedge hclk) push_button_input <= 1'b0;
    rd(apr_pkg::OFS_EVENT, 32'h100);
    wr(apr_pkg::OFS_CTRL, 32'h5);
    cyc(1);
    chk(hibernate, 1'b1);
    @(posedge hclk) push_button_input <= 1'b1;
    cyc(5);
    chk({hibernate, mcu_reset}, 2'b00);
    cyc(25);
    chk(mcu_reset, 1'b1);
    @(posedge hclk) push_button_input <= 1'b0;
    cyc(4);
    chk(mcu_reset, 1'b0);
    wr(apr_pkg::OFS_CTRL, 32'h3);
    @(posedge hclk) push_button_input <= 1'b1;
    wr(apr_pkg::OFS_EVENT, 32'h1FF);
    rd(apr_pkg::OFS_EVENT, 32'h0);
    @(posedge hclk) push_button_input <= 1'b0;
    cyc(4);
    rd(apr_pkg::OFS_EVENT, 32'h100);
    // low level reads as released once the button goes back to active high
    @(posedge hclk) push_button_input <= 1'b0;
    wr(apr_pkg::OFS_CTRL, 32'h80);
    @(posedge hclk) {temp_warn_above, temp_warn_hyst_above} <= 2'b11;
    cyc(5);
    rd(apr_pkg::OFS_STATE, 32'h9);
    @(posedge hclk) {temp_warn_above, temp_warn_hyst_above} <= 2'b00;
    cyc(4);
    chk(main_interrupt_line, 1'b1);
    cyc(12);
    chk(main_interrupt_line, 1'b0);
    @(posedge hclk) {temp_fault_above, temp_fault_hyst_above} <= 2'b11;
    cyc(5);
    chk({power_shutdown, gates_on}, 2'b10);
    @(posedge hclk) {temp_fault_above, temp_fault_hyst_above} <= 2'b00;
    cyc(4);
    chk(power_shutdown, 1'b1);
    cyc(12);
    chk(power_shutdown, 1'b0);
    chk(mcu_reset, 1'b0);
    end_of_test();
  end
endmodule
